/* rtl/aigc_pkg.sv */
// Package for the input and gain configuration register block
`default_nettype none
package aigc_pkg;
    localparam logic [3:0] AIGC_CFG_ADDR      = 4'h0;
    localparam logic [7:0] AIGC_CFG_RESET     = 8'h00;
    localparam int         AIGC_SEL_MSB       = 7;
    localparam int         AIGC_SEL_LSB       = 4;
    localparam int         AIGC_GAIN_MSB      = 3;
    localparam int         AIGC_GAIN_LSB      = 1;
    localparam int         AIGC_BYP_BIT       = 0;
    localparam logic [2:0] AIGC_GAIN_MAX_BYP  = 3'h2;
    localparam logic [3:0] AIGC_SEL_DIFF_LAST = 4'h7;
    localparam logic [3:0] AIGC_SEL_REF_MON   = 4'hc;
    localparam logic [3:0] AIGC_SEL_SUP_MON   = 4'hd;
    localparam logic [3:0] AIGC_SEL_SHORT     = 4'he;
    localparam logic [3:0] AIGC_SEL_RESERVED  = 4'hf;

    typedef struct packed {
        logic [3:0] input_selector;
        logic [2:0] gain_code;
        logic       amp_bypass;
    } aigc_cfg_t;

    typedef struct packed {
        logic       amp_enable;
        logic       single_ended;
        logic       ref_monitor;
        logic       supply_monitor;
        logic       mid_short;
        logic       reserved_sel;
        logic [7:0] gain_value;
    } aigc_front_t;
endpackage : aigc_pkg
`default_nettype wire

/* rtl/aigc_cfg_reg.sv */
// Input selector, gain and amplifier bypass configuration register
// Functional notes
// - Register at address zero, resets to zero.
// - Bits 7:4 select input; 0-7 differential pairs.
// - Codes 1100/1101 route monitors, amplifier bypassed.
// - Code 1110 shorts inputs; 1111 reserved.
// - Bits 3:1 gain code, gain two-to-code.
// - Bit 0 requests amplifier bypass.
// - Gains 8 to 128 keep amplifier enabled unless a monitor code is selected.
// - Bypass effective only for gains 1,2,4.
// - Reached by read/write commands; kept in power-down.
`default_nettype none
module aigc_cfg_reg
    import aigc_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        wr_stb_in,
    input  wire logic [3:0]  wr_addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic [3:0]  rd_addr_in,
    input  wire logic        power_down_in,
    output logic      [7:0]  rd_data_out,
    output logic             rd_hit_out,
    output aigc_cfg_t        cfg_out,
    output aigc_front_t      front_out
);
    aigc_cfg_t   cfg_q;
    aigc_cfg_t   cfg_d;
    aigc_front_t front_d;
    aigc_front_t front_q;

    // Monitor codes force the bypass whatever the bypass bit holds
    function automatic logic is_monitor(input logic [3:0] sel);
        is_monitor = (sel == AIGC_SEL_REF_MON) || (sel == AIGC_SEL_SUP_MON);
    endfunction : is_monitor

    wire logic       wr_hit   = wr_stb_in && (wr_addr_in == AIGC_CFG_ADDR);
    wire logic       rd_hit   = (rd_addr_in == AIGC_CFG_ADDR);
    wire logic       low_gain = (cfg_q.gain_code <= AIGC_GAIN_MAX_BYP);
    wire logic       mon_sel  = is_monitor(cfg_q.input_selector);
    wire logic [7:0] gain_onehot;

    // One decoded line per gain step; the front end wants a one-hot weight,
    // which avoids a shifter on the analog control path
    for (genvar k = 0; k < 8; k++)
    begin : g_gain
        assign gain_onehot[k] = (cfg_q.gain_code == 3'(k));
    end

    // Power-down does not gate the write path; contents simply persist
    assign cfg_d = wr_hit ? aigc_cfg_t'(wr_data_in) : cfg_q;

    always_comb
    begin
        front_d                = '0;
        front_d.amp_enable     = !((cfg_q.amp_bypass && low_gain) || mon_sel);
        front_d.single_ended   = cfg_q.input_selector[3] &&
                                 (cfg_q.input_selector[3:2] == 2'h2);
        front_d.ref_monitor    = (cfg_q.input_selector == AIGC_SEL_REF_MON);
        front_d.supply_monitor = (cfg_q.input_selector == AIGC_SEL_SUP_MON);
        front_d.mid_short      = (cfg_q.input_selector == AIGC_SEL_SHORT);
        front_d.reserved_sel   = (cfg_q.input_selector == AIGC_SEL_RESERVED);
        front_d.gain_value     = gain_onehot;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            cfg_q <= aigc_cfg_t'(AIGC_CFG_RESET);
        else
            cfg_q <= cfg_d;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            front_q <= '0;
        else
            front_q <= front_d;
    end

    // Read data is combinational from the stored value so a read in the write cycle sees the old value
    assign rd_data_out = rd_hit ? cfg_q : 8'h00;
    assign rd_hit_out  = rd_hit;
    assign cfg_out     = cfg_q;
    assign front_out   = front_q;

    a_reset_clears: assert property (@(posedge mclk_in)
        rst_in |=> (cfg_q == 8'h00)) else $error("config not cleared by reset");

    a_write_stores: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_hit |=> (cfg_q == $past(wr_data_in))) else $error("write not stored");

    a_hold_no_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        !wr_hit |=> $stable(cfg_q)) else $error("config changed without write");

    a_high_gain_on: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_q.gain_code > 3'h2 && !mon_sel) |=> front_q.amp_enable)
        else $error("amplifier off at high gain");

    a_bypass_low_off: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_q.amp_bypass && cfg_q.gain_code <= 3'h2) |=> !front_q.amp_enable)
        else $error("bypass ignored at low gain");

    a_monitor_bypass: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_q.input_selector == 4'hc || cfg_q.input_selector == 4'hd) |=> !front_q.amp_enable)
        else $error("monitor without bypass");

    a_enable_default: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!cfg_q.amp_bypass && !mon_sel) |=> front_q.amp_enable)
        else $error("amplifier off without bypass");

    a_gain_power: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.gain_value == (8'h01 << $past(cfg_q.gain_code))))
        else $error("gain value mismatch");

    a_short_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.mid_short == ($past(cfg_q.input_selector) == 4'he)))
        else $error("short decode wrong");

    a_read_back: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rd_addr_in == 4'h0) |-> (rd_data_out == cfg_q))
        else $error("read data mismatch");

    // Power-down must never disturb the stored settings
    a_pd_retains: assert property (@(posedge mclk_in) disable iff (rst_in)
        (power_down_in && !wr_hit) |=> $stable(cfg_q))
        else $error("config lost in power-down");

    // Writes aimed at other registers are silently ignored here
    a_other_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_stb_in && (wr_addr_in != AIGC_CFG_ADDR)) |=> $stable(cfg_q))
        else $error("foreign write changed config");

    a_read_miss: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rd_addr_in != AIGC_CFG_ADDR) |-> (rd_data_out == 8'h00))
        else $error("read miss not zero");

    a_hit_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |-> (rd_hit_out == (rd_addr_in == AIGC_CFG_ADDR)))
        else $error("read hit flag wrong");

    a_front_reset: assert property (@(posedge mclk_in)
        rst_in |=> (front_q == '0))
        else $error("front end not cleared by reset");

    a_sel_field: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_hit |=> (cfg_q.input_selector == $past(wr_data_in[7:4])))
        else $error("selector field not stored");

    a_gain_field: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_hit |=> (cfg_q.gain_code == $past(wr_data_in[3:1])))
        else $error("gain field not stored");

    a_bypass_field: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_hit |=> (cfg_q.amp_bypass == $past(wr_data_in[0])))
        else $error("bypass field not stored");

    // Differential codes must raise none of the special-route flags
    a_diff_pairs: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_q.input_selector <= AIGC_SEL_DIFF_LAST) |=>
        !(front_q.single_ended || front_q.ref_monitor || front_q.supply_monitor ||
          front_q.mid_short || front_q.reserved_sel))
        else $error("differential code flagged");

    a_ref_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.ref_monitor == ($past(cfg_q.input_selector) == 4'hc)))
        else $error("reference monitor decode wrong");

    a_sup_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.supply_monitor == ($past(cfg_q.input_selector) == 4'hd)))
        else $error("supply monitor decode wrong");

    a_reserved_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.reserved_sel == ($past(cfg_q.input_selector) == 4'hf)))
        else $error("reserved code not flagged");

    // Ground-referenced codes are 1000 to 1011; the host keeps their limits
    a_single_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (front_q.single_ended == ($past(cfg_q.input_selector[3:2]) == 2'h2)))
        else $error("single-ended decode wrong");

    a_route_onehot: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> $onehot0({front_q.single_ended, front_q.ref_monitor,
                           front_q.supply_monitor, front_q.mid_short, front_q.reserved_sel}))
        else $error("more than one route flag");

    a_gain_onehot: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> $onehot(front_q.gain_value))
        else $error("gain weight not one-hot");

    // A set bypass bit is ignored at high gain unless a monitor is routed
    a_bypass_high: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cfg_q.amp_bypass && !low_gain && !mon_sel) |=> front_q.amp_enable)
        else $error("bypass honoured at high gain");

    a_cfg_mirror: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> (cfg_out == $past(cfg_d)))
        else $error("config output does not follow next value");
endmodule : aigc_cfg_reg
`default_nettype wire

/* dv/aigc_host_model.sv */
// Host model that issues register write commands
`default_nettype none
module aigc_host_model
(
    input  wire logic       mclk_in,
    output var  logic       wr_stb_out,
    output var  logic [3:0] wr_addr_out,
    output var  logic [7:0] wr_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_stb_out, wr_addr_out, wr_data_out} = '0;
    task automatic write_reg(input logic [3:0] a, input logic [7:0] v, output logic [7:0] s);
        s = v;
        // Ground-referenced inputs need the bypass and a gain of 4 at most
        if (s[7:6] == 2'b10)
        begin
            s[0] = 1'b1;
            s[3:1] = (s[3:1] > 3'h2) ? 3'h2 : s[3:1];
        end
        @(posedge mclk_in);
        {wr_stb_out, wr_addr_out, wr_data_out} <= {1'b1, a, s};
        @(posedge mclk_in);
        // Released bus shows inverted data so a stale value cannot pass
        {wr_stb_out, wr_addr_out, wr_data_out} <= {1'b0, ~a, ~s};
    endtask : write_reg
endmodule : aigc_host_model
`default_nettype wire

/* dv/adc_input_gain_config_register_bench.sv */
// Self-checking bench for the input and gain configuration register
`default_nettype none
module adc_input_gain_config_register_bench
    import aigc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_in, wr_stb_in, power_down_in, rd_hit_out;
    logic [3:0] wr_addr_in, rd_addr_in, a;
    logic [7:0] wr_data_in, rd_data_out, s, e;
    aigc_cfg_t cfg_out;
    aigc_front_t front_out;
    int seed = 63944, miscompares = 0, total_checks = 0, cycles = 0;
    aigc_cfg_reg aigc_cfg_reg_i (.mclk_in, .rst_in, .wr_stb_in, .wr_addr_in, .wr_data_in,
        .rd_addr_in, .power_down_in, .rd_data_out, .rd_hit_out, .cfg_out, .front_out);
    aigc_host_model aigc_host_model_i (.mclk_in, .wr_stb_out(wr_stb_in),
        .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in));
    function automatic aigc_front_t model(input logic [7:0] v);
        int sel = v[7:4], g = v[3:1];
        return {(v[0] && g <= 2) || sel == 12 || sel == 13 ? 1'b0 : 1'b1, sel >= 8 && sel <= 11,
            sel == 12, sel == 13, sel == 14, sel == 15, 8'(1 << g)};
    endfunction : model
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        mclk_in = 0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        {rst_in, power_down_in, rd_addr_in, e} = {1'b1, 13'h0};
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 48; i++)
        begin
            a = (i % 7 == 3) ? 4'($random(seed)) | 4'h1 : 4'h0;
            aigc_host_model_i.write_reg(a, {4'(i), 4'($random(seed))}, s);
            power_down_in <= i[1];
            e = (a == 4'h0) ? s : e;
            repeat (2) @(posedge mclk_in);
            #1;
            chk(cfg_out, e);
            chk(rd_data_out, e);
            chk(front_out, model(e));
        end
        rd_addr_in <= 4'h3;
        rst_in <= 1'b1;
        @(posedge mclk_in);
        #1;
        chk({rd_hit_out, rd_data_out, cfg_out}, 0);
        end_of_test();
    end
endmodule : adc_input_gain_config_register_bench
`default_nettype wire
